// *** common/mps_consts.svh ***
// Constants for the multipoint gain and phase selector: counts, widths, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

`define MPS_NUM_PHASES     3
`define MPS_NUM_REGIONS    5
`define MPS_WORD_W         32
`define MPS_REGION_W       3
`define MPS_REGION_TOP     3'h4
`define MPS_REGION_INC_MAX 3'h3
`define MPS_REGION_DEC_MIN 3'h1
`define MPS_REGION_RESET   3'h0
`define MPS_MPEN_RESET     1'h0
`define MPS_COEFF_FRAC     27
`define MPS_CLK_HZ         100000000
`define MPS_DSP_RATE_HZ    4000
`define MPS_DSP_TICK_CYCLES (`MPS_CLK_HZ / `MPS_DSP_RATE_HZ)
`define MPS_DIV_W          15

`endif

// *** common/mps_pkg.sv ***
// Types shared by the multipoint gain and phase selector modules.
// Assumes mps_consts.svh sits on the include path.
`include "mps_consts.svh"

package mps_pkg;

    // One signed 32-bit coefficient, threshold or sample word.
    typedef logic signed [`MPS_WORD_W-1:0] mps_word_t;

    // One word for each calibration region.
    typedef mps_word_t [`MPS_NUM_REGIONS-1:0] mps_region_words_t;

    // Region index of one phase.
    typedef logic [`MPS_REGION_W-1:0] mps_region_t;

    // Calibration coefficients of one phase.
    typedef struct packed {
        mps_word_t         baseGain;     // Gain applied at every amplitude.
        mps_region_words_t regionGain;   // Extra gain, one per region.
        mps_region_words_t regionPhase;  // Phase coefficient, one per region.
    } mps_phase_cfg_t;

    // Region thresholds shared by all phases.
    typedef struct packed {
        mps_region_words_t low;   // Leave a region downward below this.
        mps_region_words_t high;  // Leave a region upward above this.
    } mps_thresholds_t;

endpackage

// *** verilog/mps_region_sel.sv ***
// Region tracker for one phase: moves the region index up or down by one step.
// Assumes a one-cycle sample tick and an rms word that is stable on that tick.
`timescale 1ns/1ps
`include "mps_consts.svh"

module mps_region_sel
    import mps_pkg::*;
(
    input  wire logic            ref_clk,    // System clock.
    input  wire logic            rst,        // Asynchronous reset, active high.
    input  wire logic            tick,       // One-cycle pulse per new rms sample.
    input  wire mps_word_t       rmsValue,   // Current rms amplitude of this phase.
    input  wire mps_thresholds_t thresholds, // Low and high region thresholds.
    output mps_region_t          region      // Region index now tracked.
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        mps_region_t region;  // Tracked region index.
    } mps_sel_state_t;

    mps_sel_state_t state;       // Registered state.
    mps_sel_state_t next_state;  // Next state.

    // Only one step is taken per sample, which gives the hysteresis band between
    // neighbouring regions instead of jumping straight to the final region.
    always_comb begin
        next_state = state;
        if (tick) begin
            if (rmsValue > thresholds.high[state.region]) begin
                if (state.region <= `MPS_REGION_INC_MAX) begin
                    next_state.region = state.region + 3'h1;
                end
            end else if (rmsValue < thresholds.low[state.region]) begin
                if (state.region >= `MPS_REGION_DEC_MIN) begin
                    next_state.region = state.region - 3'h1;
                end
            end
        end
    end

    // Region starts at zero so a fresh part uses the base coefficients.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state.region <= `MPS_REGION_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign region = state.region;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_region_in_range: assert property (state.region <= `MPS_REGION_TOP)
        else $error("Region index left the range of five regions.");

    a_region_step_up: assert property (
        tick && rmsValue > thresholds.high[state.region] && state.region <= 3'h3
        |=> state.region == $past(state.region) + 3'h1)
        else $error("Region did not step up above the high threshold.");

    a_region_step_down: assert property (
        tick && !(rmsValue > thresholds.high[state.region])
        && rmsValue < thresholds.low[state.region] && state.region >= 3'h1
        |=> state.region == $past(state.region) - 3'h1)
        else $error("Region did not step down below the low threshold.");

    a_region_only_tick: assert property (!tick |=> $stable(state.region))
        else $error("Region changed without a sample tick.");

endmodule

// *** verilog/mps_gain_phase_select.sv ***
// Top of the multipoint gain and phase selector for three current channels.
// Assumes coefficient and threshold inputs are held steady by the register side.
//
// Overview of operation
// - Base gain always scales the current channel.
// - Enabled: extra region gain from rms region.
// - Enabled: phase coefficient follows same region.
// - Above high threshold, below four: step up.
// - Else below low threshold, above zero: down.
// - Active region index shown for each phase.
// - Multipoint correction off after reset.
// - Disabled: base gain only, no extra gain.
// - Disabled: region-zero phase coefficient always used.
// - Rms driven selection refreshed at 4 kSPS.
`timescale 1ns/1ps
`include "mps_consts.svh"

module mps_gain_phase_select
    import mps_pkg::*;
#(
    parameter int DSP_TICK_CYCLES = `MPS_DSP_TICK_CYCLES  // Clock cycles per rms sample.
)(
    input  wire logic                              ref_clk,          // 100 MHz clock.
    input  wire logic                              rst,              // Async reset, high.
    input  wire logic                              multipointEnable, // Setup enable bit.
    input  wire mps_thresholds_t                   thresholds,       // Region thresholds.
    input  wire mps_phase_cfg_t [`MPS_NUM_PHASES-1:0] phaseCfg,      // Per-phase coeffs.
    input  wire mps_word_t [`MPS_NUM_PHASES-1:0]   currentRmsValue,  // Per-phase rms.
    input  wire mps_word_t [`MPS_NUM_PHASES-1:0]   currentSample,    // Raw current samples.
    input  wire logic                              sampleValid,      // Samples valid pulse.
    output mps_word_t [`MPS_NUM_PHASES-1:0]        gainedCurrent,    // Corrected samples.
    output logic                                   gainedValid,      // Corrected valid pulse.
    output mps_word_t [`MPS_NUM_PHASES-1:0]        phaseCoeff,       // Applied phase coeff.
    output mps_region_t [`MPS_NUM_PHASES-1:0]      activeRegionIndicator, // Applied region.
    output logic                                   dspTick           // Rms sample strobe.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Types, constants and helpers.

    localparam logic [`MPS_DIV_W-1:0] DIV_LAST = `MPS_DIV_W'(DSP_TICK_CYCLES - 1);

    typedef struct packed {
        logic [`MPS_DIV_W-1:0]                 divCnt;     // Rate divider count.
        logic                                  tick;       // Rms sample strobe.
        logic                                  mpEn;       // Registered enable bit.
        logic                                  s1Valid;    // Base-gain stage valid.
        logic                                  outValid;   // Output stage valid.
        mps_word_t [`MPS_NUM_PHASES-1:0]       s1;         // After base gain.
        mps_word_t [`MPS_NUM_PHASES-1:0]       gained;     // After region gain.
        mps_word_t [`MPS_NUM_PHASES-1:0]       phaseOut;   // Applied phase coeff.
        mps_region_t [`MPS_NUM_PHASES-1:0]     indicator;  // Applied region.
    } mps_top_state_t;

    mps_top_state_t state;       // Registered state.
    mps_top_state_t next_state;  // Next state.

    mps_region_t [`MPS_NUM_PHASES-1:0] trackedRegion;  // Region from each tracker.

    // Applies (1 + g / 2^27) to a sample; the product is cut back to 32 bits,
    // so gains that push a full-scale sample past the word range will wrap.
    function automatic mps_word_t apply_gain(input mps_word_t x, input mps_word_t g);
        logic signed [2*`MPS_WORD_W-1:0] prod;
        prod = x * g;
        return x + prod[`MPS_COEFF_FRAC +: `MPS_WORD_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Region trackers, one per phase.

    // Trackers run even while multipoint is off, so turning it on picks up a
    // region that already fits the signal instead of climbing from zero.
    for (genvar p = 0; p < `MPS_NUM_PHASES; p++) begin : g_phase
        mps_region_sel u_sel (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .tick       (state.tick),
            .rmsValue   (currentRmsValue[p]),
            .thresholds (thresholds),
            .region     (trackedRegion[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        next_state = state;
        // Divider gives one tick per rms sample period.
        if (state.divCnt == DIV_LAST) begin
            next_state.divCnt = '0;
            next_state.tick   = 1'b1;
        end else begin
            next_state.divCnt = state.divCnt + `MPS_DIV_W'(1);
            next_state.tick   = 1'b0;
        end
        // The enable is registered once, so all three phases change mode on one edge.
        // A sample already in stage one takes the mode and region registered on the edge that loaded it.
        next_state.mpEn     = multipointEnable;
        next_state.s1Valid  = sampleValid;
        next_state.outValid = state.s1Valid;
        for (int p = 0; p < `MPS_NUM_PHASES; p++) begin
            // Base gain first, on every sample.
            if (sampleValid) begin
                next_state.s1[p] = apply_gain(currentSample[p], phaseCfg[p].baseGain);
            end
            if (state.mpEn) begin
                next_state.indicator[p] = trackedRegion[p];
                next_state.phaseOut[p]  = phaseCfg[p].regionPhase[trackedRegion[p]];
                if (state.s1Valid) begin
                    next_state.gained[p] = apply_gain(state.s1[p],
                        phaseCfg[p].regionGain[trackedRegion[p]]);
                end
            end else begin
                next_state.indicator[p] = `MPS_REGION_RESET;
                next_state.phaseOut[p]  = phaseCfg[p].regionPhase[0];
                if (state.s1Valid) begin
                    next_state.gained[p] = state.s1[p];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Enable clears on reset so a part always powers up in single-point mode.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state      <= '0;
            state.mpEn <= `MPS_MPEN_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign gainedCurrent         = state.gained;
    assign gainedValid           = state.outValid;
    assign phaseCoeff            = state.phaseOut;
    assign activeRegionIndicator = state.indicator;
    assign dspTick               = state.tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_valid_two_cycles: assert property (sampleValid |=> ##1 gainedValid)
        else $error("Corrected sample did not follow two cycles after input.");

    a_base_gain_stage: assert property (
        sampleValid |=> state.s1[0] == apply_gain($past(currentSample[0]),
                                                  $past(phaseCfg[0].baseGain)))
        else $error("Base gain stage does not match the base coefficient.");

    a_single_point_gain: assert property (
        state.s1Valid && !state.mpEn |=> gainedCurrent[1] == $past(state.s1[1]))
        else $error("Extra gain applied with multipoint off.");

    a_multi_point_gain: assert property (
        state.s1Valid && state.mpEn
        |=> gainedCurrent[2] == apply_gain($past(state.s1[2]),
                $past(phaseCfg[2].regionGain[trackedRegion[2]])))
        else $error("Region gain does not match the tracked region.");

    a_phase_region_zero: assert property (
        !state.mpEn |=> phaseCoeff[0] == $past(phaseCfg[0].regionPhase[0]))
        else $error("Phase coefficient not region zero with multipoint off.");

    a_phase_follows_region: assert property (
        state.mpEn |=> phaseCoeff[1] == $past(phaseCfg[1].regionPhase[trackedRegion[1]])
                       && activeRegionIndicator[1] == $past(trackedRegion[1]))
        else $error("Phase coefficient or indicator off the tracked region.");

    a_indicator_zero_off: assert property (
        !state.mpEn |=> activeRegionIndicator == '0)
        else $error("Indicator not zero with multipoint off.");

    a_tick_spacing: assert property (dspTick |-> state.divCnt == '0 ##1 !dspTick)
        else $error("Rms sample tick lasted more than one cycle.");

    a_tick_at_wrap: assert property (state.divCnt == DIV_LAST |=> dspTick)
        else $error("Rms sample tick missing at divider wrap.");

    a_enable_follows: assert property (multipointEnable |=> state.mpEn)
        else $error("Enable bit not taken in one cycle.");

    // Clearing the enable must fall back to single-point mode on the next edge.
    a_enable_clears: assert property (!multipointEnable |=> !state.mpEn)
        else $error("Enable bit not cleared in one cycle.");

    // Corrected samples hold their value while nothing is in flight.
    a_gain_holds: assert property (
        !state.s1Valid |=> $stable(gainedCurrent))
        else $error("Corrected sample changed with no sample in flight.");

    // The valid pulse may only follow a stage-one result.
    a_valid_only_after: assert property (!state.s1Valid |=> !gainedValid)
        else $error("Corrected valid raised with no sample in flight.");

    // The last phase gets its own base gain, not a neighbour's.
    a_base_gain_last: assert property (
        sampleValid |=> state.s1[2] == apply_gain($past(currentSample[2]),
                                                  $past(phaseCfg[2].baseGain)))
        else $error("Base gain stage of the last phase does not match.");

    // Single-point mode passes the first phase on with no extra gain.
    a_single_gain_first: assert property (
        state.s1Valid && !state.mpEn |=> gainedCurrent[0] == $past(state.s1[0]))
        else $error("Extra gain applied to the first phase with multipoint off.");

    // Single-point mode pins the last phase to the region-zero coefficient too.
    a_phase_zero_last: assert property (
        !state.mpEn |=> phaseCoeff[2] == $past(phaseCfg[2].regionPhase[0]))
        else $error("Last phase coefficient not region zero with multipoint off.");

    // The indicator of the first and last phases never names a region beyond the fifth.
    a_indicator_range: assert property (
        activeRegionIndicator[0] <= `MPS_REGION_TOP
        && activeRegionIndicator[2] <= `MPS_REGION_TOP)
        else $error("Region indicator outside the five regions.");

endmodule

// *** verif/test_mps_gain_phase_select.sv ***
// Self-checking testbench for the multipoint gain and phase selector top.
// Assumes mps_pkg is compiled first and mps_consts.svh is on the include path.
`timescale 1ns/1ps
`include "mps_consts.svh"

module test_mps_gain_phase_select
    import mps_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////////////////////
    localparam int TICK = 8;                      // Short rms period keeps the run brief.
    localparam int NP   = `MPS_NUM_PHASES;        // Phases driven in parallel.

    logic                    ref_clk = 1'b0;            // Bench clock, 100 MHz.
    logic                    rst = 1'b1;                // Reset, held high at start.
    logic                    multipointEnable = 1'b0;   // Enable bit, off as after reset.
    logic                    sampleValid = 1'b0;        // Sample strobe.
    mps_thresholds_t         thresholds;                // Shared region thresholds.
    mps_phase_cfg_t [NP-1:0] phaseCfg;                  // Per-phase coefficients.
    mps_word_t [NP-1:0]      currentRmsValue;           // Per-phase rms stimulus.
    mps_word_t [NP-1:0]      currentSample;             // Raw samples.
    mps_word_t [NP-1:0]      gainedCurrent;             // Corrected samples.
    mps_word_t [NP-1:0]      phaseCoeff;                // Applied phase coefficients.
    mps_region_t [NP-1:0]    activeRegionIndicator;     // Region seen at the ports.
    mps_region_t [NP-1:0]    expRegion;                 // Region the bench predicts.
    logic                    gainedValid;               // Corrected sample strobe.
    logic                    dspTick;                   // Rms sample strobe.
    int                      bad_count = 0;             // Mismatches seen.
    int                      checks = 0;                // Comparisons made.

    mps_gain_phase_select #(.DSP_TICK_CYCLES(TICK)) DUT (
        .ref_clk(ref_clk), .rst(rst), .multipointEnable(multipointEnable),
        .thresholds(thresholds), .phaseCfg(phaseCfg), .currentRmsValue(currentRmsValue),
        .currentSample(currentSample), .sampleValid(sampleValid),
        .gainedCurrent(gainedCurrent), .gainedValid(gainedValid), .phaseCoeff(phaseCoeff),
        .activeRegionIndicator(activeRegionIndicator), .dspTick(dspTick)
    );

    // The clock toggles every half period of 5 ns.
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////////////
    // One region step of the hysteresis walk; compares are signed on purpose.
    function automatic mps_region_t step(input mps_region_t r, input mps_word_t v);
        if ($signed(v) > $signed(thresholds.high[r]) && r <= 3'h3) return r + 3'h1;
        if ($signed(v) < $signed(thresholds.low[r]) && r >= 3'h1) return r - 3'h1;
        return r;
    endfunction

    // Fixed point gain, x plus the product scaled down by two to the 27th.
    function automatic mps_word_t gmul(input mps_word_t x, input mps_word_t g);
        logic signed [63:0] p;
        p = x * g;
        return x + p[58:27];
    endfunction

    // The prediction moves on every tick edge, so no tick can slip past unseen.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            expRegion <= '0;
        end else if (dspTick === 1'b1) begin
            for (int p = 0; p < NP; p++) expRegion[p] <= step(expRegion[p], currentRmsValue[p]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Compare one value and report a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Region and phase coefficient of every phase; region zero applies while disabled.
    task automatic checkOut();
        mps_region_t r;
        for (int p = 0; p < NP; p++) begin
            r = multipointEnable ? expRegion[p] : 3'h0;
            check(32'(activeRegionIndicator[p]), 32'(r), "region");
            check(phaseCoeff[p], phaseCfg[p].regionPhase[r], "phase coeff");
        end
    endtask

    // One sample set; the result must appear two edges later for exactly one cycle.
    task automatic sendSample(input mps_word_t x);
        mps_word_t e;
        for (int p = 0; p < NP; p++) currentSample[p] = x + 32'(p * 32'h0011_0000);
        sampleValid = 1'b1;
        @(negedge ref_clk);
        sampleValid = 1'b0;
        check(32'(gainedValid), 32'h0, "valid early");
        @(negedge ref_clk);
        check(32'(gainedValid), 32'h1, "valid");
        for (int p = 0; p < NP; p++) begin
            e = gmul(currentSample[p], phaseCfg[p].baseGain);
            if (multipointEnable) e = gmul(e, phaseCfg[p].regionGain[expRegion[p]]);
            check(gainedCurrent[p], e, "gained current");
        end
        @(negedge ref_clk);
        check(32'(gainedValid), 32'h0, "valid pulse");
    endtask

    // Wait for n ticks, set the enable just after each, then check outputs and gain.
    task automatic tickCheck(input logic en, input int n);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 0;
            @(negedge ref_clk);
            while (dspTick !== 1'b1 && w < 4 * TICK) begin
                @(negedge ref_clk);
                w++;
            end
            check(32'(w < 4 * TICK), 32'h1, "tick seen");
            multipointEnable = en;
            repeat (3) @(negedge ref_clk);
            checkOut();
            sendSample(32'h0123_4567);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, tick period, climb, disable, descend.
    initial begin
        int n;
        for (int r = 0; r < `MPS_NUM_REGIONS; r++) begin
            thresholds.low[r]  = 32'(r * 100);
            thresholds.high[r] = (r == 4) ? 32'h7fff_ffff : 32'(r * 100 + 150);
        end
        for (int p = 0; p < NP; p++) begin
            phaseCfg[p].baseGain = 32'h00cc_cccd + 32'(p);
            for (int r = 0; r < `MPS_NUM_REGIONS; r++) begin
                phaseCfg[p].regionGain[r]  = 32'(32'h0010_0000 * (r + 1) + p);
                phaseCfg[p].regionPhase[r] = 32'h00a0_0000 + 32'(r * 16 + p);
            end
        end
        currentRmsValue = '0;
        currentSample = '0;
        repeat (16) @(negedge ref_clk);
        for (int p = 0; p < NP; p++) begin
            check(32'(activeRegionIndicator[p]), 32'h0, "reset region");
            check(phaseCoeff[p], 32'h0, "reset phase");
            check(gainedCurrent[p], 32'h0, "reset gain");
        end
        rst = 1'b0;
        n = 0;
        while (dspTick !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
        n = 0;
        do begin @(negedge ref_clk); n++; end while (dspTick !== 1'b1 && n < 100);
        check(32'(n), 32'(TICK), "tick period");
        // Phase 1 sits between low[1] and high[0], so it must stay in region zero.
        currentRmsValue = {32'd225, 32'd120, 32'd1000};
        tickCheck(1'b0, 2);
        tickCheck(1'b1, 3);
        tickCheck(1'b0, 1);
        currentRmsValue = {32'd50, 32'd120, 32'd0};
        tickCheck(1'b1, 5);
        finish_test();
    end

    // Watchdog: the tests need about 1.3 us, so 20 us means a hang.
    initial begin
        #20us;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

endmodule
